// ===== rtl/ssi_encoder_end.sv
// encoder end: position counter and serial shift-out
`timescale 1ns/100ps
module ssi_encoder_end #(
	parameter int          N        = ssi_pkg::WORD_BITS,
	parameter int          MONO     = ssi_pkg::MONO_CYC,
	parameter logic        GRAY_OUT = 1'b1
) (
	input  wire logic      CORE_CLK_IN,
	input  wire logic      RST_B_IN,
	input  wire logic      STEP_IN,      // one movement step, cw when high dir
	input  wire logic      STEP_CW_IN,   // step direction: 1 = clockwise
	output logic [N-1:0]   POS_OUT,
	ssi_link_if.encoder    link
);
	logic [2:0]   clk_s_q, dir_s_q, zero_s_q;
	logic [N-1:0] pos_q, shift_q;
	logic [$clog2(N+2)-1:0] bit_q;
	logic [ssi_pkg::CNT_W-1:0] mono_q;
	logic         data_q, busy_q;

	// bit counter codes: LSB shown, then the tail after the last fall
	localparam int BW = $clog2(N+2);
	localparam logic [BW-1:0] LAST_BIT = BW'(N);
	localparam logic [BW-1:0] TAIL_BIT = BW'(N+1);

	function automatic logic [N-1:0] to_gray(input logic [N-1:0] b);
		return b ^ (b >> 1);
	endfunction

	// synchronised pins: bit 1 is stable copy, bit 2 previous
	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			clk_s_q  <= 3'h7;
			dir_s_q  <= 3'h0;
			zero_s_q <= 3'h7;
		end else begin
			clk_s_q  <= {clk_s_q[1:0], link.clk_p};
			dir_s_q  <= {dir_s_q[1:0], link.dir_sel};
			zero_s_q <= {zero_s_q[1:0], link.zero_n};
		end
	end

	wire clk_fall  = clk_s_q[2] & ~clk_s_q[1];
	wire clk_rise  = ~clk_s_q[2] & clk_s_q[1];
	wire zero_fall = zero_s_q[2] & ~zero_s_q[1];
	wire mono_done = (mono_q == '0);
	wire count_up  = STEP_CW_IN ^ dir_s_q[2];
	wire [N-1:0] snap = GRAY_OUT ? to_gray(pos_q) : pos_q;

	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pos_q <= '0;
		end else if (zero_fall) begin
			pos_q <= '0;
		end else if (STEP_IN) begin
			pos_q <= count_up ? pos_q + 1'b1 : pos_q - 1'b1;
		end
	end

	// monoflop retriggered on each falling edge
	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			mono_q <= '0;
		end else if (clk_fall) begin
			mono_q <= ssi_pkg::CNT_W'(MONO);
		end else if (!mono_done) begin
			mono_q <= mono_q - 1'b1;
		end
	end

	// shift engine: freeze, shift, low, ring
	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			shift_q <= '0;
			bit_q   <= '0;
			busy_q  <= 1'b0;
			data_q  <= 1'b1;
		end else if (clk_fall && (!busy_q || mono_done)) begin
			shift_q <= snap;
			bit_q   <= '0;
			busy_q  <= 1'b1;
		end else if (clk_fall && busy_q && bit_q == LAST_BIT) begin
			// last falling edge: lsb taken, enter tail
			bit_q <= TAIL_BIT;
		end else if (clk_fall && busy_q && bit_q == TAIL_BIT) begin
			// pulse n+2 in time: repeat frozen word
			bit_q <= '0;
		end else if (clk_rise && busy_q && bit_q == TAIL_BIT) begin
			// hold low after lsb, changed on a high clock
			data_q <= 1'b0;
		end else if (clk_rise && busy_q && bit_q != LAST_BIT) begin
			data_q <= shift_q[N-1-bit_q];
			bit_q  <= bit_q + 1'b1;
		end else if (busy_q && mono_done) begin
			// timeout over, line back to rest
			busy_q <= 1'b0;
			data_q <= 1'b1;
		end
	end

	assign link.data_p = data_q;
	assign POS_OUT     = pos_q;
endmodule : ssi_encoder_end

// ===== rtl/ssi_pkg.sv
// shared constants for the synchronous serial position port
package ssi_pkg;
	localparam int          WORD_BITS     = 25;       // clock-bit positions n
	localparam int          CLK_NS        = 5;        // core clock period
	localparam int          MONO_NS       = 20000;    // monoflop time in ns
	localparam int          MONO_CYC      = MONO_NS / CLK_NS;
	localparam int          HALF_CYC      = 10;       // controller half period minus one, in core cycles
	localparam int          CNT_W         = 16;
	localparam logic [31:0] ZERO_HOLD_US  = 32'd1100000; // zero-set hold, us
	localparam logic [31:0] ZERO_HOLD_CYC = ZERO_HOLD_US * 32'd200;
endpackage : ssi_pkg

// ===== rtl/ssi_link_if.sv
// link wires between the position controller and the encoder
`timescale 1ns/100ps
interface ssi_link_if;
	logic clk_p;    // clock line, controller drives
	logic data_p;   // data line, encoder drives
	logic dir_sel;  // counting direction input
	logic zero_n;   // zero-set input, acts on falling edge
	modport encoder    (input clk_p, dir_sel, zero_n, output data_p);
	modport controller (output clk_p, dir_sel, zero_n, input data_p);
endinterface : ssi_link_if

// ===== rtl/ssi_controller_end.sv
// controller end: clock burst generator and word receiver
`timescale 1ns/100ps
module ssi_controller_end #(
	parameter int          N    = ssi_pkg::WORD_BITS,
	parameter int          HALF = ssi_pkg::HALF_CYC
) (
	input  wire logic      CORE_CLK_IN,
	input  wire logic      RST_B_IN,
	input  wire logic      START_IN,   // request one read
	input  wire logic      DIR_IN,     // counting direction level
	input  wire logic      ZERO_IN,    // pulse: request zero-set
	output logic [N-1:0]   WORD_OUT,
	output logic           VALID_OUT,
	ssi_link_if.controller link
);
	logic [2:0]  data_s_q;
	logic [7:0]  half_q;
	logic [$clog2(2*N+4)-1:0] edge_q;
	logic        run_q, clk_q, valid_q, dir_q, zero_q;
	logic [31:0] zhold_q;
	logic [N-1:0] rx_q;

	// synchronise returning data
	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) data_s_q <= 3'h7;
		else           data_s_q <= {data_s_q[1:0], link.data_p};
	end

	// start only when data has returned high
	wire line_idle = data_s_q[2] & ~run_q;
	wire tick      = (half_q == '0);

	// burst of n+1 clocks, divided from core clock
	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			run_q   <= 1'b0;
			clk_q   <= 1'b1;
			half_q  <= '0;
			edge_q  <= '0;
			rx_q    <= '0;
			valid_q <= 1'b0;
		end else begin
			valid_q <= 1'b0;
			if (!run_q) begin
				clk_q <= 1'b1;
				if (START_IN && line_idle) begin
					run_q  <= 1'b1;
					half_q <= 8'(HALF);
					edge_q <= '0;
				end
			end else if (tick) begin
				half_q <= 8'(HALF);
				clk_q  <= ~clk_q;
				edge_q <= edge_q + 1'b1;
				// sample data just before each falling edge after first
				if (clk_q && edge_q != '0)
					rx_q <= {rx_q[N-2:0], data_s_q[2]};
				if (edge_q == ($clog2(2*N+4))'(2*N+1)) begin
					run_q   <= 1'b0;
					clk_q   <= 1'b1;
					valid_q <= 1'b1;
				end
			end else begin
				half_q <= half_q - 1'b1;
			end
		end
	end

	// zero-set held low for the minimum duration
	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			zero_q  <= 1'b1;
			zhold_q <= '0;
			dir_q   <= 1'b0;
		end else begin
			dir_q <= DIR_IN;
			if (ZERO_IN && zero_q) begin
				zero_q  <= 1'b0;
				zhold_q <= ssi_pkg::ZERO_HOLD_CYC;
			end else if (zhold_q != '0) begin
				zhold_q <= zhold_q - 1'b1;
			end else begin
				zero_q <= 1'b1;
			end
		end
	end

	assign link.clk_p   = clk_q;
	assign link.dir_sel = dir_q;
	assign link.zero_n  = zero_q;
	assign WORD_OUT     = rx_q;
	assign VALID_OUT    = valid_q;
endmodule : ssi_controller_end

// ===== dv/ssi_link_asserts.sv
// timing checks on the serial link wires
`timescale 1ns/100ps
module ssi_link_asserts #(
	parameter int MONO = 64,
	parameter int HALF = 10
) (
	input wire logic CORE_CLK_IN,
	input wire logic RST_B_IN,
	input wire logic clk_p,
	input wire logic data_p,
	input wire logic zero_n
);
	logic [15:0] hi_q;
	// cycles the clock line has stayed high
	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) hi_q <= '0;
		else if (!clk_p) hi_q <= '0;
		else if (hi_q != 16'hffff) hi_q <= hi_q + 16'h0001;
	end
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	property p_idle; hi_q > MONO + 8 |-> data_p; endproperty
	a_idle: assert property (p_idle)
		else $error("data low on idle link");
	property p_rise; $rose(data_p) |-> hi_q < 8 || hi_q > MONO - 2 * HALF;
	endproperty
	a_rise: assert property (p_rise)
		else $error("data rose before timeout");
	property p_low; !clk_p |-> $stable(data_p); endproperty
	a_low: assert property (p_low)
		else $error("data moved while clock low");
	property p_chg; $changed(data_p) |-> hi_q > 0; endproperty
	a_chg: assert property (p_chg)
		else $error("data moved off a high clock");
	property p_half; $fell(clk_p) |-> ##[1:16] clk_p; endproperty
	a_half: assert property (p_half)
		else $error("clock low too long");
	property p_start; $fell(clk_p) && hi_q > HALF + 4 |-> $past(data_p);
	endproperty
	a_start: assert property (p_start)
		else $error("burst began with data low");
	property p_frz; $fell(clk_p) && hi_q > HALF + 4 |-> data_p [*8];
	endproperty
	a_frz: assert property (p_frz)
		else $error("data moved at burst start");
	property p_zero; $fell(zero_n) |-> !zero_n [*8]; endproperty
	a_zero: assert property (p_zero)
		else $error("zero-set pulse too short");
endmodule // ssi_link_asserts

// ===== dv/ssi_encoder_position_port_tb.sv
// bench: both link ends, random steps, reads and zero-set
`timescale 1ns/100ps
module ssi_encoder_position_port_tb;
	localparam int N = ssi_pkg::WORD_BITS;
	logic         clk, rst_b, step, cw, start, dir, zero, valid;
	logic [N-1:0] word, pos, exp_q;
	int           seed, error_cnt, checks;
	ssi_link_if link ();
	ssi_encoder_end #(.MONO(64)) i_ssi_encoder_end (.CORE_CLK_IN(clk),
		.RST_B_IN(rst_b), .STEP_IN(step), .STEP_CW_IN(cw),
		.POS_OUT(pos), .link(link));
	ssi_controller_end i_ssi_controller_end (.CORE_CLK_IN(clk),
		.RST_B_IN(rst_b), .START_IN(start), .DIR_IN(dir), .ZERO_IN(zero),
		.WORD_OUT(word), .VALID_OUT(valid), .link(link));
	ssi_link_asserts #(.MONO(64)) i_ssi_link_asserts (.CORE_CLK_IN(clk),
		.RST_B_IN(rst_b), .clk_p(link.clk_p), .data_p(link.data_p),
		.zero_n(link.zero_n));
	// expected gray form of a position
	function automatic logic [N-1:0] gray(input logic [N-1:0] b);
		return b ^ (b >> 1);
	endfunction
	// word compare
	task cmp(input logic [N-1:0] got, input logic [N-1:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// bounded wait on valid or on data line high
	task wait_on(input bit on_data);
		for (int n = 0; (on_data ? link.data_p : valid) !== 1'b1; n++) begin
			if (n > 3000) begin
				error_cnt++;
				conclude();
			end
			@(negedge clk);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		{rst_b, step, cw, start, dir, zero} = 6'h00;
		seed = 66880;
		exp_q = '0;
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		for (int r = 0; r < 12; r++) begin
			dir = r[0];
			if (r == 7) begin
				zero = 1'b1;
				@(negedge clk);
				zero = 1'b0;
				exp_q = '0;
			end
			repeat (6) @(negedge clk);
			// random steps, wrapping through zero both ways
			repeat ($random(seed) & 31) begin
				step = 1'b1;
				cw = 1'($random(seed));
				exp_q = (cw ^ dir) ? exp_q + 1'b1 : exp_q - 1'b1;
				@(negedge clk);
				step = 1'b0;
				@(negedge clk);
			end
			start = 1'b1;
			@(negedge clk);
			start = 1'b0;
			wait_on(1'b0);
			cmp(word, gray(exp_q));
			cmp(pos, exp_q);
			// let the monoflop run out before the next read
			repeat (80) @(negedge clk);
			wait_on(1'b1);
		end
		conclude();
	end
endmodule // ssi_encoder_position_port_tb
